//--- rtl/oau_defs.svh
`ifndef OAU_DEFS_SVH
`define OAU_DEFS_SVH
`define OAU_DATA_W 32
`define OAU_MSB 31
`define OAU_NREG 8
`define OAU_SP_IDX 3'h7
`define OAU_STEP_B 32'h00000001
`define OAU_STEP_W 32'h00000002
`define OAU_STEP_L 32'h00000004
`define OAU_STEP_SPB 32'h00000002
`define OAU_LONG_OFS 32'h00000002
`define OAU_QUICK_LSB 9
`define OAU_QUICK_W 3
`endif

//--- rtl/oau_pkg.sv
package oau_pkg;
    typedef enum logic [1:0] {OAU_SZ_BYTE, OAU_SZ_WORD, OAU_SZ_LONG,
        OAU_SZ_BIT} oau_size_e;
    typedef enum logic [3:0] {
        OAU_M_DREG, OAU_M_AREG, OAU_M_IND, OAU_M_POST, OAU_M_PRE,
        OAU_M_OFS, OAU_M_IDX, OAU_M_ABSW, OAU_M_ABSL, OAU_M_PCOFS,
        OAU_M_PCIDX, OAU_M_IMM, OAU_M_QUICK, OAU_M_IMPL
    } oau_mode_e;
    typedef enum logic [1:0] {OAU_I_SR, OAU_I_USP, OAU_I_SSP,
        OAU_I_PC} oau_impl_e;
endpackage : oau_pkg

//--- rtl/oau_if.sv
`timescale 1ns/1ps
// Carries the address computation request and its answer
interface oau_if;
    logic [31:0] base;
    logic [31:0] indexVal;
    logic [15:0] extWord0;
    logic [15:0] extWord1;
    logic [3:0] mode;
    logic [1:0] size;
    logic isStack;
    logic [31:0] effectiveAddr;
    logic [31:0] regUpdate;
    logic regUpdEn;
    logic misaligned;
    modport calc (input base, indexVal, extWord0, extWord1, mode, size,
        isStack, output effectiveAddr, regUpdate, regUpdEn, misaligned);
    modport user (output base, indexVal, extWord0, extWord1, mode, size,
        isStack, input effectiveAddr, regUpdate, regUpdEn, misaligned);
endinterface : oau_if

//--- rtl/oau_ea_calc.sv
`timescale 1ns/1ps
`include "oau_defs.svh"
module oau_ea_calc
    import oau_pkg::*;
(
    // Request and answer
    oau_if.calc ea
);
    oau_mode_e mode;
    oau_size_e size;
    logic [31:0] step;
    logic [31:0] shortDisp;
    logic [31:0] longDisp;
    logic [31:0] decBase;
    logic multiByte;

    // Operand step and sign-extended displacements
    assign mode = oau_mode_e'(ea.mode);
    assign size = oau_size_e'(ea.size);
    assign step = (size == OAU_SZ_LONG) ? `OAU_STEP_L :
        (size == OAU_SZ_WORD) ? `OAU_STEP_W :
        ea.isStack ? `OAU_STEP_SPB : `OAU_STEP_B;
    assign shortDisp = {{24{ea.extWord0[7]}}, ea.extWord0[7:0]};
    assign longDisp = {{16{ea.extWord0[15]}}, ea.extWord0};
    assign decBase = ea.base - step;
    assign multiByte = (size == OAU_SZ_WORD) || (size == OAU_SZ_LONG);

    // Effective address by mode
    always_comb begin
        ea.effectiveAddr = ea.base;
        ea.regUpdate = ea.base;
        ea.regUpdEn = 1'b0;
        unique case (mode)
            OAU_M_POST: begin
                ea.regUpdate = ea.base + step;
                ea.regUpdEn = 1'b1;
            end
            OAU_M_PRE: begin
                ea.effectiveAddr = decBase;
                ea.regUpdate = decBase;
                ea.regUpdEn = 1'b1;
            end
            OAU_M_OFS, OAU_M_PCOFS: begin
                ea.effectiveAddr = ea.base + longDisp;
            end
            OAU_M_IDX, OAU_M_PCIDX: begin
                ea.effectiveAddr = ea.base + ea.indexVal + shortDisp;
            end
            OAU_M_ABSW: begin
                ea.effectiveAddr = longDisp;
            end
            OAU_M_ABSL: begin
                ea.effectiveAddr = {ea.extWord0, ea.extWord1};
            end
            default: begin
            end
        endcase
    end

    // Multibyte memory accesses must sit on even addresses
    assign ea.misaligned = multiByte && ea.effectiveAddr[0] &&
        (mode inside {OAU_M_IND, OAU_M_POST, OAU_M_PRE, OAU_M_OFS,
        OAU_M_IDX, OAU_M_ABSW, OAU_M_ABSL, OAU_M_PCOFS,
        OAU_M_PCIDX});
endmodule : oau_ea_calc

//--- rtl/operand_addressing_unit.sv
`timescale 1ns/1ps
`include "oau_defs.svh"
module operand_addressing_unit
    import oau_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Operation request
    input wire logic opValid,
    input wire logic [3:0] opMode,
    input wire logic [1:0] opSize,
    input wire logic [2:0] opReg,
    input wire logic opIdxIsAddr,
    input wire logic [2:0] opIdxReg,
    input wire logic opIdxLong,
    input wire logic [1:0] opImplSel,
    input wire logic [15:0] opcodeWord,
    input wire logic [15:0] extWord0,
    input wire logic [15:0] extWord1,
    input wire logic [4:0] opBitNum,
    input wire logic supervisorMode,
    input wire logic [31:0] progCounter,
    input wire logic [15:0] statusReg,
    // Register write request
    input wire logic wrValid,
    input wire logic wrIsAddr,
    input wire logic [2:0] wrReg,
    input wire logic [1:0] wrSize,
    input wire logic [31:0] wrData,
    // Answer
    output logic resValid,
    output logic [31:0] effectiveAddr,
    output logic [31:0] operandVal,
    output logic opRefused,
    output logic misaligned,
    // Memory byte lanes
    input wire logic [31:0] memLong,
    output logic [31:0] memHighWordAddr,
    output logic [31:0] memLowWordAddr,
    output logic [7:0] memEvenByte,
    output logic [7:0] memOddByte
);
    logic [31:0] dataRegs [`OAU_NREG];
    logic [31:0] addrRegs [`OAU_NREG];
    logic [31:0] userStackPtr_reg;
    logic [31:0] supervisorStackPtr_reg;
    logic resValid_reg;
    logic [31:0] ea_reg;
    logic [31:0] val_reg;
    logic refused_reg;
    logic misal_reg;
    logic [31:0] memHi_reg;
    logic [31:0] memLo_reg;
    logic [7:0] memEven_reg;
    logic [7:0] memOdd_reg;
    oau_if eaBus();
    oau_mode_e mode;
    oau_size_e size;
    logic [31:0] activeSp;
    logic [31:0] baseAddr;
    logic [31:0] dataSel;
    logic [31:0] idxRaw;
    logic [31:0] idxVal;
    logic [31:0] srcVal;
    logic [31:0] immVal;
    logic [31:0] quickVal;
    logic [31:0] implVal;
    logic [31:0] valNext;
    logic byteToAddr;
    logic wrByteToAddr;
    logic [31:0] wrAddrVal;
    logic [31:0] chkStep;

    // Reads an address register or the active stack pointer
    // Register value comes in as an argument so callers track changes
    function automatic logic [31:0] readAddr(input logic [2:0] idx,
        input logic [31:0] sp, input logic [31:0] av);
        readAddr = (idx == `OAU_SP_IDX) ? sp : av;
    endfunction : readAddr

    // Merges a sized value into the low part of a data register; bit size XORs the whole value in
    function automatic logic [31:0] mergeLow(input logic [31:0] old,
        input logic [31:0] val, input oau_size_e sz);
        unique case (sz)
            OAU_SZ_BYTE: mergeLow = {old[31:8], val[7:0]};
            OAU_SZ_WORD: mergeLow = {old[31:16], val[15:0]};
            OAU_SZ_LONG: mergeLow = val;
            OAU_SZ_BIT: mergeLow = val ^ old;
        endcase
    endfunction : mergeLow

    // Operand view of a register value by size
    function automatic logic [31:0] sizeView(input logic [31:0] v,
        input oau_size_e sz, input logic [4:0] bitNum);
        unique case (sz)
            OAU_SZ_BYTE: sizeView = {24'h000000, v[7:0]};
            OAU_SZ_WORD: sizeView = {16'h0000, v[15:0]};
            OAU_SZ_LONG: sizeView = v;
            OAU_SZ_BIT: sizeView = {31'h00000000, v[bitNum]};
        endcase
    endfunction : sizeView

    // Request decode and register selection
    assign mode = oau_mode_e'(opMode);
    assign size = oau_size_e'(opSize);
    assign activeSp = supervisorMode ? supervisorStackPtr_reg :
        userStackPtr_reg;
    assign baseAddr = (mode == OAU_M_PCOFS || mode == OAU_M_PCIDX) ?
        progCounter :
        readAddr(opReg, activeSp, addrRegs[opReg]);
    assign dataSel = dataRegs[opReg];
    assign idxRaw = opIdxIsAddr ?
        readAddr(opIdxReg, activeSp, addrRegs[opIdxReg]) :
        dataRegs[opIdxReg];
    assign idxVal = opIdxLong ? idxRaw :
        {{16{idxRaw[15]}}, idxRaw[15:0]};
    assign byteToAddr = (size == OAU_SZ_BYTE || size == OAU_SZ_BIT) &&
        (mode == OAU_M_AREG);

    // Address calculation
    assign eaBus.base = baseAddr;
    assign eaBus.indexVal = idxVal;
    assign eaBus.extWord0 = extWord0;
    assign eaBus.extWord1 = extWord1;
    assign eaBus.mode = opMode;
    assign eaBus.size = opSize;
    assign eaBus.isStack = (opReg == `OAU_SP_IDX);
    oau_ea_calc u_calc (
        .ea(eaBus)
    );

    // Immediate, quick and implied operands
    assign immVal = (size == OAU_SZ_LONG) ? {extWord0, extWord1} :
        (size == OAU_SZ_WORD) ? {16'h0000, extWord0} :
        {24'h000000, extWord0[7:0]};
    assign quickVal = {29'h00000000,
        opcodeWord[`OAU_QUICK_LSB +: `OAU_QUICK_W]};
    assign implVal = (opImplSel == OAU_I_SR) ? {16'h0000, statusReg} :
        (opImplSel == OAU_I_USP) ? userStackPtr_reg :
        (opImplSel == OAU_I_SSP) ? supervisorStackPtr_reg :
        progCounter;
    assign srcVal = (mode == OAU_M_AREG) ?
        ((size == OAU_SZ_WORD) ? {16'h0000, baseAddr[15:0]} : baseAddr) :
        sizeView(dataSel, size, opBitNum);
    assign valNext = (mode == OAU_M_IMM) ? immVal :
        (mode == OAU_M_QUICK) ? quickVal :
        (mode == OAU_M_IMPL) ? implVal :
        (mode == OAU_M_AREG || mode == OAU_M_DREG) ? srcVal :
        sizeView(memLong, size, opBitNum);

    // Address destination value, word sign-extended
    assign wrAddrVal = (wrSize == OAU_SZ_WORD) ?
        {{16{wrData[15]}}, wrData[15:0]} : wrData;
    assign wrByteToAddr = wrIsAddr &&
        (wrSize == OAU_SZ_BYTE || wrSize == OAU_SZ_BIT);

    // Data register file
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `OAU_NREG; i++) begin
                dataRegs[i] <= 32'h00000000;
            end
        end else if (wrValid && !wrIsAddr) begin
            dataRegs[wrReg] <= mergeLow(dataRegs[wrReg], wrData,
                oau_size_e'(wrSize));
        end
    end

    // Address registers and both stack pointers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `OAU_NREG; i++) begin
                addrRegs[i] <= 32'h00000000;
            end
            userStackPtr_reg <= 32'h00000000;
            supervisorStackPtr_reg <= 32'h00000000;
        end else if (wrValid && wrIsAddr && !wrByteToAddr) begin
            if (wrReg != `OAU_SP_IDX) begin
                addrRegs[wrReg] <= wrAddrVal;
            end else if (supervisorMode) begin
                supervisorStackPtr_reg <= wrAddrVal;
            end else begin
                userStackPtr_reg <= wrAddrVal;
            end
        end else if (opValid && eaBus.regUpdEn) begin
            if (opReg != `OAU_SP_IDX) begin
                addrRegs[opReg] <= eaBus.regUpdate;
            end else if (supervisorMode) begin
                supervisorStackPtr_reg <= eaBus.regUpdate;
            end else begin
                userStackPtr_reg <= eaBus.regUpdate;
            end
        end
    end

    // Answer registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            resValid_reg <= 1'b0;
            ea_reg <= 32'h00000000;
            val_reg <= 32'h00000000;
            refused_reg <= 1'b0;
            misal_reg <= 1'b0;
        end else begin
            resValid_reg <= opValid;
            refused_reg <= opValid && byteToAddr;
            misal_reg <= opValid && eaBus.misaligned;
            if (opValid) begin
                ea_reg <= eaBus.effectiveAddr;
                val_reg <= valNext;
            end
        end
    end

    // Memory word addresses and byte lanes of the answer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            memHi_reg <= 32'h00000000;
            memLo_reg <= 32'h00000000;
            memEven_reg <= 8'h00;
            memOdd_reg <= 8'h00;
        end else if (opValid) begin
            memHi_reg <= {eaBus.effectiveAddr[31:1], 1'b0};
            memLo_reg <= {eaBus.effectiveAddr[31:1], 1'b0} +
                `OAU_LONG_OFS;
            memEven_reg <= valNext[15:8];
            memOdd_reg <= valNext[7:0];
        end
    end

    assign resValid = resValid_reg;
    assign effectiveAddr = ea_reg;
    assign operandVal = val_reg;
    assign opRefused = refused_reg;
    assign misaligned = misal_reg;
    assign memHighWordAddr = memHi_reg;
    assign memLowWordAddr = memLo_reg;
    assign memEvenByte = memEven_reg;
    assign memOddByte = memOdd_reg;

    // Address step the rules give, kept apart from the calculator
    assign chkStep = (size == OAU_SZ_LONG) ? `OAU_STEP_L :
        (size == OAU_SZ_WORD) ? `OAU_STEP_W :
        (opReg == `OAU_SP_IDX) ? `OAU_STEP_SPB : `OAU_STEP_B;

    // Requests whose register result shows one cycle later
    sequence s_postReq;
        opValid && mode == OAU_M_POST && opReg != `OAU_SP_IDX &&
            !(wrValid && wrIsAddr);
    endsequence
    sequence s_spByteReq;
        opValid && mode == OAU_M_POST && opReg == `OAU_SP_IDX &&
            size == OAU_SZ_BYTE && !(wrValid && wrIsAddr);
    endsequence
    sequence s_addrWordWr;
        wrValid && wrIsAddr && wrSize == OAU_SZ_WORD &&
            wrReg != `OAU_SP_IDX;
    endsequence
    sequence s_addrByteWr;
        wrValid && wrIsAddr && wrSize == OAU_SZ_BYTE &&
            wrReg != `OAU_SP_IDX && !opValid;
    endsequence

    // Register updates and addresses of postincrement and predecrement
    a_post_step: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_postReq |=> addrRegs[$past(opReg)] ==
        $past(baseAddr) + $past(chkStep))
        else $error("postincrement step wrong");
    a_post_ea: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_POST |=>
        effectiveAddr == $past(baseAddr))
        else $error("postincrement address wrong");
    a_pre_ea: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_PRE |=>
        effectiveAddr == $past(baseAddr) - $past(chkStep))
        else $error("predecrement address wrong");
    a_sp_byte: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_spByteReq |=> activeSp == $past(activeSp) + `OAU_STEP_SPB ||
        supervisorMode != $past(supervisorMode))
        else $error("stack byte step not two");

    // Address sums, extension words, quick and implied operands
    a_ofs_ea: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_OFS |=> effectiveAddr ==
        $past(baseAddr) + {{16{$past(extWord0[15])}}, $past(extWord0)})
        else $error("offset address wrong");
    a_idx_ea: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_IDX |=> effectiveAddr ==
        $past(baseAddr) + $past(idxVal) +
        {{24{$past(extWord0[7])}}, $past(extWord0[7:0])})
        else $error("indexed address wrong");
    a_pc_ofs: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_PCOFS |=> effectiveAddr ==
        $past(progCounter) +
        {{16{$past(extWord0[15])}}, $past(extWord0)})
        else $error("pc offset address wrong");
    a_abs_short: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_ABSW |=>
        effectiveAddr == {{16{$past(extWord0[15])}}, $past(extWord0)})
        else $error("absolute short address wrong");
    a_abs_long: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_ABSL |=>
        effectiveAddr == {$past(extWord0), $past(extWord1)})
        else $error("absolute long address wrong");
    a_quick_val: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_QUICK |=> operandVal ==
        {29'h00000000,
        $past(opcodeWord[`OAU_QUICK_LSB +: `OAU_QUICK_W])})
        else $error("quick operand wrong");
    a_impl_pc: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_IMPL && opImplSel == OAU_I_PC |=>
        operandVal == $past(progCounter))
        else $error("implied counter wrong");

    // Register widths, partial updates, odd addresses and long word pairing
    a_byte_refuse: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_AREG && size == OAU_SZ_BYTE |=>
        opRefused && resValid)
        else $error("address byte not refused");
    a_addr_word: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_addrWordWr |=> addrRegs[$past(wrReg)] ==
        {{16{$past(wrData[15])}}, $past(wrData[15:0])})
        else $error("address word not extended");
    a_addr_nobyte: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_addrByteWr |=> addrRegs[$past(wrReg)] ==
        $past(addrRegs[wrReg]))
        else $error("address byte write landed");
    a_data_keep: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wrValid && !wrIsAddr && wrSize == OAU_SZ_BYTE |=>
        dataRegs[$past(wrReg)][31:8] ==
        $past(dataRegs[wrReg][31:8]))
        else $error("upper data bits changed");
    a_bit_view: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_DREG && size == OAU_SZ_BIT |=>
        operandVal == {31'h00000000, $past(dataSel[opBitNum])})
        else $error("bit operand wrong");
    a_odd_flag: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        opValid && mode == OAU_M_IND && size == OAU_SZ_WORD &&
        baseAddr[0] |=> misaligned)
        else $error("odd word not flagged");
    a_long_pair: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        resValid |-> memLowWordAddr == memHighWordAddr + `OAU_LONG_OFS)
        else $error("long word pairing wrong");
endmodule : operand_addressing_unit

//--- sim/oau_mem_model.sv
`timescale 1ns/1ps
// Byte-wide memory handing back a long word in big-endian order
module oau_mem_model (
    // Lookup
    input wire logic [31:0] addr,
    // Operand
    output logic [31:0] memLong
);
    logic [7:0] cells [16];
    logic [3:0] a;
    // Each byte holds its own distinct value
    initial begin
        for (int i = 0; i < 16; i++) begin
            cells[i] = 8'hA0 + 8'(i);
        end
    end
    // High byte at the given address, the others follow upward
    assign a = addr[3:0];
    assign memLong = {cells[a], cells[a + 4'h1], cells[a + 4'h2],
        cells[a + 4'h3]};
endmodule : oau_mem_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    import oau_pkg::*;
    // Clock, reset and tallies
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    int failures = 0;
    int cmpCount = 0;
    int cycles = 0;
    // Request side
    logic opValid = 1'h0;
    logic [3:0] opMode = 4'h0;
    logic [1:0] opSize = 2'h0;
    logic [2:0] opReg = 3'h0;
    logic opIdxIsAddr = 1'h0;
    logic [2:0] opIdxReg = 3'h0;
    logic opIdxLong = 1'h0;
    logic [1:0] opImplSel = 2'h0;
    logic [15:0] opcodeWord = 16'h0;
    logic [15:0] extWord0 = 16'h0;
    logic [15:0] extWord1 = 16'h0;
    logic [4:0] opBitNum = 5'h0;
    logic supervisorMode = 1'h0;
    logic [31:0] progCounter = 32'h0;
    logic [15:0] statusReg = 16'h0;
    logic wrValid = 1'h0;
    logic wrIsAddr = 1'h0;
    logic [2:0] wrReg = 3'h0;
    logic [1:0] wrSize = 2'h0;
    logic [31:0] wrData = 32'h0;
    logic [31:0] memAddr = 32'h0;
    // Answer side
    logic resValid;
    logic opRefused;
    logic misaligned;
    logic [31:0] effectiveAddr;
    logic [31:0] operandVal;
    logic [31:0] memLong;
    logic [31:0] memHighWordAddr;
    logic [31:0] memLowWordAddr;
    logic [7:0] memEvenByte;
    logic [7:0] memOddByte;
    logic [31:0] v;

    operand_addressing_unit operand_addressing_unit_inst (.clk_sys, .rstn,
        .opValid, .opMode, .opSize, .opReg, .opIdxIsAddr, .opIdxReg,
        .opIdxLong, .opImplSel, .opcodeWord, .extWord0, .extWord1,
        .opBitNum, .supervisorMode, .progCounter, .statusReg, .wrValid,
        .wrIsAddr, .wrReg, .wrSize, .wrData, .resValid, .effectiveAddr,
        .operandVal, .opRefused, .misaligned, .memLong, .memHighWordAddr,
        .memLowWordAddr, .memEvenByte, .memOddByte);
    oau_mem_model oau_mem_model_inst (.addr(memAddr), .memLong(memLong));

    // Clock of 5 ns period
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h want %h", $time, msg, got,
                exp);
        end
    endtask : chk

    task automatic wr(input logic isA, input logic [2:0] r,
        input logic [1:0] sz, input logic [31:0] d);
        @(posedge clk_sys);
        wrValid <= 1'h1;
        wrIsAddr <= isA;
        wrReg <= r;
        wrSize <= sz;
        wrData <= d;
        @(posedge clk_sys);
        wrValid <= 1'h0;
    endtask : wr

    task automatic op(input logic [3:0] m, input logic [1:0] sz,
        input logic [2:0] r, input logic [15:0] e0, input logic [15:0] e1,
        input logic [31:0] ma);
        @(posedge clk_sys);
        opValid <= 1'h1;
        opMode <= m;
        opSize <= sz;
        opReg <= r;
        extWord0 <= e0;
        extWord1 <= e1;
        memAddr <= ma;
        @(posedge clk_sys);
        opValid <= 1'h0;
        #1;
        chk(32'(resValid), 32'h1, "answer pulse");
    endtask : op

    task automatic rd(input logic isA, input logic [2:0] r,
        input logic [1:0] sz);
        op(isA ? OAU_M_AREG : OAU_M_DREG, sz, r, 16'h0, 16'h0, 32'h0);
        v = operandVal;
    endtask : rd

    task automatic t_regs();
        wr(1'h0, 3'h3, OAU_SZ_LONG, 32'h89ABCDEF);
        wr(1'h0, 3'h3, OAU_SZ_BYTE, 32'h00000011);
        rd(1'h0, 3'h3, OAU_SZ_LONG);
        chk(v, 32'h89ABCD11, "byte write");
        chk(32'(v[31]), 32'h1, "top bit");
        wr(1'h0, 3'h3, OAU_SZ_WORD, 32'h00002233);
        rd(1'h0, 3'h3, OAU_SZ_LONG);
        chk(v, 32'h89AB2233, "word write");
        wr(1'h1, 3'h1, OAU_SZ_WORD, 32'h00008001);
        wr(1'h1, 3'h1, OAU_SZ_BYTE, 32'h00000055);
        rd(1'h1, 3'h1, OAU_SZ_LONG);
        chk(v, 32'hFFFF8001, "addr word write");
        rd(1'h1, 3'h1, OAU_SZ_BYTE);
        chk(32'(opRefused), 32'h1, "addr byte");
        rd(1'h1, 3'h1, OAU_SZ_WORD);
        chk(32'(v[15:0]), 32'h8001, "addr word read");
        chk(32'(opRefused), 32'h0, "addr word kept");
        rd(1'h0, 3'h3, OAU_SZ_BYTE);
        chk(v, 32'h00000033, "byte read");
        @(posedge clk_sys);
        opBitNum <= 5'h1F;
        op(OAU_M_DREG, OAU_SZ_BIT, 3'h3, 16'h0, 16'h0, 32'h0);
        chk(operandVal, 32'h1, "bit 31");
        wr(1'h0, 3'h3, OAU_SZ_BIT, 32'h00000001);
        rd(1'h0, 3'h3, OAU_SZ_LONG);
        chk(v, 32'h89AB2232, "bit write");
        $display("test regs done");
    endtask : t_regs

    task automatic t_steps();
        logic [1:0] sz [3] = '{OAU_SZ_BYTE, OAU_SZ_WORD, OAU_SZ_LONG};
        logic [31:0] st [3] = '{32'h1, 32'h2, 32'h4};
        for (int i = 0; i < 3; i++) begin
            wr(1'h1, 3'h2, OAU_SZ_LONG, 32'h00000100);
            op(OAU_M_POST, sz[i], 3'h2, 16'h0, 16'h0, 32'h0);
            chk(effectiveAddr, 32'h100, "post address");
            rd(1'h1, 3'h2, OAU_SZ_LONG);
            chk(v, 32'h100 + st[i], "post step");
            op(OAU_M_PRE, sz[i], 3'h2, 16'h0, 16'h0, 32'h0);
            chk(effectiveAddr, 32'h100, "pre address");
        end
        wr(1'h1, 3'h7, OAU_SZ_LONG, 32'h00000200);
        op(OAU_M_POST, OAU_SZ_BYTE, 3'h7, 16'h0, 16'h0, 32'h0);
        rd(1'h1, 3'h7, OAU_SZ_LONG);
        chk(v, 32'h202, "stack post byte");
        op(OAU_M_PRE, OAU_SZ_BYTE, 3'h7, 16'h0, 16'h0, 32'h0);
        chk(effectiveAddr, 32'h200, "stack pre byte");
        $display("test steps done");
    endtask : t_steps

    task automatic t_sums();
        @(posedge clk_sys);
        progCounter <= 32'h00004000;
        opIdxReg <= 3'h5;
        wr(1'h1, 3'h4, OAU_SZ_LONG, 32'h00001000);
        wr(1'h0, 3'h5, OAU_SZ_LONG, 32'h0001FFF0);
        op(OAU_M_OFS, OAU_SZ_WORD, 3'h4, 16'hFFFE, 16'h0, 32'h0);
        chk(effectiveAddr, 32'hFFE, "offset");
        op(OAU_M_IDX, OAU_SZ_WORD, 3'h4, 16'h00F0, 16'h0, 32'h0);
        chk(effectiveAddr, 32'hFE0, "index word");
        op(OAU_M_PCOFS, OAU_SZ_WORD, 3'h0, 16'h8000, 16'h0, 32'h0);
        chk(effectiveAddr, 32'hFFFFC000, "pc offset");
        @(posedge clk_sys);
        opIdxLong <= 1'h1;
        op(OAU_M_IDX, OAU_SZ_WORD, 3'h4, 16'h00F0, 16'h0, 32'h0);
        chk(effectiveAddr, 32'h20FE0, "index long");
        op(OAU_M_PCIDX, OAU_SZ_WORD, 3'h0, 16'h0004, 16'h0, 32'h0);
        chk(effectiveAddr, 32'h23FF4, "pc index");
        @(posedge clk_sys);
        opIdxIsAddr <= 1'h1;
        opIdxReg <= 3'h4;
        op(OAU_M_IDX, OAU_SZ_WORD, 3'h4, 16'h0010, 16'h0, 32'h0);
        chk(effectiveAddr, 32'h2010, "index addr");
        $display("test sums done");
    endtask : t_sums

    task automatic t_words();
        @(posedge clk_sys);
        opcodeWord <= 16'h0A00;
        op(OAU_M_ABSW, OAU_SZ_WORD, 3'h0, 16'h1234, 16'h0, 32'h0);
        chk(effectiveAddr, 32'h1234, "abs short");
        op(OAU_M_ABSL, OAU_SZ_WORD, 3'h0, 16'h00AB, 16'hCDEF, 32'h0);
        chk(effectiveAddr, 32'h00ABCDEF, "abs long");
        op(OAU_M_IMM, OAU_SZ_LONG, 3'h0, 16'h1122, 16'h3344, 32'h0);
        chk(operandVal, 32'h11223344, "imm long");
        op(OAU_M_IMM, OAU_SZ_BYTE, 3'h0, 16'h1122, 16'h3344, 32'h0);
        chk(32'(operandVal[7:0]), 32'h22, "imm byte");
        op(OAU_M_QUICK, OAU_SZ_LONG, 3'h0, 16'h0, 16'h0, 32'h0);
        chk(operandVal, 32'h5, "quick");
        wr(1'h1, 3'h3, OAU_SZ_LONG, 32'h00000004);
        op(OAU_M_IND, OAU_SZ_LONG, 3'h3, 16'h0, 16'h0, 32'h4);
        chk(operandVal, 32'hA4A5A6A7, "long order");
        chk(memHighWordAddr, 32'h4, "high word");
        chk(memLowWordAddr, 32'h6, "low word");
        chk(32'(memEvenByte), 32'hA6, "even byte");
        chk(32'(memOddByte), 32'hA7, "odd byte");
        wr(1'h1, 3'h3, OAU_SZ_LONG, 32'h00000005);
        op(OAU_M_IND, OAU_SZ_WORD, 3'h3, 16'h0, 16'h0, 32'h5);
        chk(32'(misaligned), 32'h1, "odd word");
        op(OAU_M_IND, OAU_SZ_BYTE, 3'h3, 16'h0, 16'h0, 32'h5);
        chk(32'(misaligned), 32'h0, "odd byte");
        $display("test words done");
    endtask : t_words

    task automatic t_implied();
        logic [31:0] exp [4] = '{32'h2704, 32'h200, 32'h3000, 32'h4000};
        @(posedge clk_sys);
        supervisorMode <= 1'h1;
        statusReg <= 16'h2704;
        wr(1'h1, 3'h7, OAU_SZ_LONG, 32'h00003000);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            opImplSel <= 2'(i);
            op(OAU_M_IMPL, OAU_SZ_LONG, 3'h0, 16'h0, 16'h0, 32'h0);
            chk(operandVal, exp[i], "implied");
        end
        $display("test implied done");
    endtask : t_implied

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'h1;
        #1;
        chk(effectiveAddr, 32'h0, "reset address");
        chk(32'(resValid), 32'h0, "reset pulse");
        t_regs();
        t_steps();
        t_sums();
        t_words();
        t_implied();
        final_report();
    end
endmodule : tb
